// ==== core/ptc_pkg.sv ====
package ptc_pkg;

   // Register bus geometry
   localparam int          ADDR_W          = 12;
   localparam int          DATA_W          = 32;

   // Register byte addresses
   localparam logic [11:0] OFF_PIN9_LOW    = 12'h16c;
   localparam logic [11:0] OFF_TIME_UPPER  = 12'h170;
   localparam logic [11:0] OFF_TIME_LOWER  = 12'h174;
   localparam logic [11:0] OFF_RATE_TRIM   = 12'h178;
   localparam logic [11:0] OFF_MATCH_UPPER = 12'h17c;
   localparam logic [11:0] OFF_MATCH_LOWER = 12'h180;
   localparam logic [11:0] OFF_REFILL_UP   = 12'h184;
   localparam logic [11:0] OFF_REFILL_LOW  = 12'h188;
   localparam logic [11:0] OFF_CONTROL     = 12'h1a0;
   localparam logic [11:0] OFF_IRQ_STATUS  = 12'h1a4;
   localparam logic [11:0] OFF_IRQ_MASK    = 12'h1a8;

   // Control register fields
   localparam int          CTRL_REFILL_BIT = 0;
   localparam int          CTRL_FREEZE_BIT = 1;

   // Interrupt status and mask fields
   localparam int          IRQ_W           = 2;
   localparam int          IRQ_MATCH_BIT   = 0;
   localparam int          IRQ_PIN9_BIT    = 1;

   // Reset values
   localparam logic [31:0] WORD_RESET      = 32'h00000000;
   localparam logic [63:0] TIME_RESET      = 64'h0000000000000000;
   localparam logic [1:0]  IRQ_RESET       = 2'h0;

   // Time advanced by one accumulator carry
   localparam logic [63:0] TICK_STEP       = 64'h0000000000000001;

   // APB request from the master
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } ptc_apb_req_t;

   // Holding register for a value written in two halves
   typedef struct packed {
      logic [31:0] hi;
      logic [31:0] lo;
      logic        got_hi;
      logic        got_lo;
   } ptc_stage_t;

   localparam ptc_stage_t STAGE_RESET = '0;

   // Merge one half-word write into a holding register
   function automatic ptc_stage_t ptc_stage_next(ptc_stage_t s, logic wr_hi, logic wr_lo,
                                                 logic [31:0] d);
      ptc_stage_t n;
      n = s;
      if (wr_hi) begin
         n.hi     = d;
         n.got_hi = 1'b1;
      end
      if (wr_lo) begin
         n.lo     = d;
         n.got_lo = 1'b1;
      end
      return n;
   endfunction : ptc_stage_next

endpackage : ptc_pkg

// ==== core/ptc_time_clock.sv ====
`timescale 1ns/1ns
// Operation
// R1 - A pin 9 activation latches time bits 31..0 into a read-only word, reset zero.
// R2 - One 64-bit time value, two 32-bit words, feeds every timestamp capture.
// R3 - Time advances at a nominal 100 MHz, adjustable through the addend word.
// R4 - Time update takes effect only after both time words are written.
// R5 - Time word reads return a copy saved by the snapshot command bit.
// R6 - Every cycle the addend, reset zero, is added into the divisor accumulator.
// R7 - Target is compared with time continuously; a match raises a compare event.
// R8 - New target takes effect only after both its words are written.
// R9 - On compare event with the reload bit set, reload value replaces target.
// R10 - New reload value takes effect only after both its words are written.
// R11 - Upper time word holds bits 63..32, is read/write, and resets zero.
// R12 - Reload/add bit selects replacing or adding the reload value on an event.
// R13 - Each accumulator carry advances the time value by one tick.
// R14 - The first half waits in a holding register until the second arrives.
module ptc_time_clock (
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 ce,
   input  wire ptc_pkg::ptc_apb_req_t apb_req,
   input  wire logic                 pin9_event,
   output logic [31:0]               prdata,
   output logic                      pready,
   output logic                      pslverr,
   output logic                      irq,
   output logic                      match_pulse,
   output logic [63:0]               time_now
);
   import ptc_pkg::*;

   logic [63:0]      time_value;
   logic [31:0]      accum;
   logic [31:0]      rate_trim;
   logic [63:0]      match_value;
   logic [63:0]      refill_value;
   logic [63:0]      frozen_time;
   logic [31:0]      captured_time_low;
   logic             refill_mode;
   logic [IRQ_W-1:0] irq_status;
   logic [IRQ_W-1:0] irq_mask;
   logic             pin9_q;
   logic             match_q;
   logic             rsp_valid;

   ptc_stage_t       time_stage;
   ptc_stage_t       match_stage;
   ptc_stage_t       refill_stage;
   ptc_stage_t       next_time_stage;
   ptc_stage_t       next_match_stage;
   ptc_stage_t       next_refill_stage;

   logic             wr_acc;
   logic [32:0]      next_accum;
   logic             tick;
   logic             time_commit;
   logic             match_commit;
   logic             refill_commit;
   logic             match_now;
   logic             match_event;
   logic             pin9_rise;
   logic [IRQ_W-1:0] irq_set;
   logic [IRQ_W-1:0] irq_clr;

   // True when the current write access targets the given address
   function automatic logic wr_to(logic acc, logic [11:0] addr, logic [11:0] a);
      return acc && (addr == a);
   endfunction : wr_to

   // Offsets that answer without an error
   function automatic logic is_mapped(logic [11:0] a);
      case (a)
         OFF_PIN9_LOW, OFF_TIME_UPPER, OFF_TIME_LOWER, OFF_RATE_TRIM,
         OFF_MATCH_UPPER, OFF_MATCH_LOWER, OFF_REFILL_UP, OFF_REFILL_LOW,
         OFF_CONTROL, OFF_IRQ_STATUS, OFF_IRQ_MASK: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction : is_mapped

   // Bus handshake: ready only once read data has been latched
   assign pready = ce & rsp_valid;
   assign wr_acc = apb_req.psel & apb_req.penable & apb_req.pwrite & pready;

   // Response capture; a frozen clock enable simply stretches the access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rsp_valid <= 1'b0;
         prdata    <= WORD_RESET;
         pslverr   <= 1'b0;
      end else if (ce) begin
         if (apb_req.psel && !rsp_valid) begin
            rsp_valid <= 1'b1;
            pslverr   <= ~is_mapped(apb_req.paddr);
            case (apb_req.paddr)
               OFF_PIN9_LOW:    prdata <= captured_time_low;
               OFF_TIME_UPPER:  prdata <= frozen_time[63:32]; // R5 R11
               OFF_TIME_LOWER:  prdata <= frozen_time[31:0];  // R5
               OFF_RATE_TRIM:   prdata <= rate_trim;
               OFF_MATCH_UPPER: prdata <= match_value[63:32];
               OFF_MATCH_LOWER: prdata <= match_value[31:0];
               OFF_REFILL_UP:   prdata <= refill_value[63:32];
               OFF_REFILL_LOW:  prdata <= refill_value[31:0];
               OFF_CONTROL:     prdata <= {31'h0, refill_mode};
               OFF_IRQ_STATUS:  prdata <= {30'h0, irq_status};
               OFF_IRQ_MASK:    prdata <= {30'h0, irq_mask};
               default:         prdata <= WORD_RESET;
            endcase
         end else if (apb_req.psel && apb_req.penable && rsp_valid) begin
            rsp_valid <= 1'b0;
         end
      end
   end

   // Half-word staging for the three split values
   always_comb begin
      next_time_stage   = ptc_stage_next(time_stage,
                                         wr_to(wr_acc, apb_req.paddr, OFF_TIME_UPPER),
                                         wr_to(wr_acc, apb_req.paddr, OFF_TIME_LOWER),
                                         apb_req.pwdata); // R14
      next_match_stage  = ptc_stage_next(match_stage,
                                         wr_to(wr_acc, apb_req.paddr, OFF_MATCH_UPPER),
                                         wr_to(wr_acc, apb_req.paddr, OFF_MATCH_LOWER),
                                         apb_req.pwdata); // R14
      next_refill_stage = ptc_stage_next(refill_stage,
                                         wr_to(wr_acc, apb_req.paddr, OFF_REFILL_UP),
                                         wr_to(wr_acc, apb_req.paddr, OFF_REFILL_LOW),
                                         apb_req.pwdata); // R14
   end

   // A commit needs both halves; either order is accepted
   assign time_commit   = next_time_stage.got_hi & next_time_stage.got_lo;       // R4
   assign match_commit  = next_match_stage.got_hi & next_match_stage.got_lo;     // R8
   assign refill_commit = next_refill_stage.got_hi & next_refill_stage.got_lo;   // R10

   // Holding registers drop their flags once the full value is committed
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         time_stage   <= STAGE_RESET;
         match_stage  <= STAGE_RESET;
         refill_stage <= STAGE_RESET;
      end else if (ce) begin
         time_stage   <= time_commit ? {next_time_stage.hi, next_time_stage.lo, 2'b00}
                                     : next_time_stage;
         match_stage  <= match_commit ? {next_match_stage.hi, next_match_stage.lo, 2'b00}
                                      : next_match_stage;
         refill_stage <= refill_commit ? {next_refill_stage.hi, next_refill_stage.lo, 2'b00}
                                       : next_refill_stage;
      end
   end

   // Plain software registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rate_trim   <= WORD_RESET;
         refill_mode <= 1'b0;
         irq_mask    <= IRQ_RESET;
      end else if (ce) begin
         if (wr_to(wr_acc, apb_req.paddr, OFF_RATE_TRIM)) begin
            rate_trim <= apb_req.pwdata; // R3
         end
         if (wr_to(wr_acc, apb_req.paddr, OFF_CONTROL)) begin
            refill_mode <= apb_req.pwdata[CTRL_REFILL_BIT]; // R12
         end
         if (wr_to(wr_acc, apb_req.paddr, OFF_IRQ_MASK)) begin
            irq_mask <= apb_req.pwdata[IRQ_W-1:0];
         end
      end
   end

   // Rate accumulator: the carry is the time tick, so the rate is linear in the addend
   assign next_accum = {1'b0, accum} + {1'b0, rate_trim}; // R6
   assign tick       = next_accum[32];                    // R13

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         accum <= WORD_RESET;
      end else if (ce) begin
         accum <= next_accum[31:0]; // R6
      end
   end

   // Running time; a committed software value wins over the tick of that cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         time_value <= TIME_RESET; // R11
      end else if (ce) begin
         if (time_commit) begin
            time_value <= {next_time_stage.hi, next_time_stage.lo}; // R4 R11
         end else if (tick) begin
            time_value <= time_value + TICK_STEP; // R13 R3
         end
      end
   end

   assign time_now = time_value; // R2

   // Snapshot copy for software reads, taken from the live time
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frozen_time <= TIME_RESET;
      end else if (ce) begin
         if (wr_to(wr_acc, apb_req.paddr, OFF_CONTROL) && apb_req.pwdata[CTRL_FREEZE_BIT]) begin
            frozen_time <= time_value; // R5
         end
      end
   end

   // Compare on equality; edge detect so a parked time raises one event only
   assign match_now   = (time_value == match_value);   // R7
   assign match_event = match_now & ~match_q;          // R7
   assign match_pulse = 1'b0; // Reserved; the compare event shows in the status word

   // match_q resets high so the all-zero reset state raises no event
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         match_q <= 1'b1;
      end else if (ce) begin
         match_q <= match_now;
      end
   end

   // Active compare value: software commit first, then reload or add on an event
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         match_value <= TIME_RESET;
      end else if (ce) begin
         if (match_commit) begin
            match_value <= {next_match_stage.hi, next_match_stage.lo}; // R8
         end else if (match_event) begin
            if (refill_mode) begin
               match_value <= refill_value;               // R9 R12
            end else begin
               match_value <= match_value + refill_value; // R12
            end
         end
      end
   end

   // Active reload value
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         refill_value <= TIME_RESET;
      end else if (ce) begin
         if (refill_commit) begin
            refill_value <= {next_refill_stage.hi, next_refill_stage.lo}; // R10
         end
      end
   end

   // Pin 9 is synchronous; its rising edge is the activation
   assign pin9_rise = pin9_event & ~pin9_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin9_q            <= 1'b0;
         captured_time_low <= WORD_RESET; // R1
      end else if (ce) begin
         pin9_q <= pin9_event;
         if (pin9_rise) begin
            captured_time_low <= time_value[31:0]; // R1 R2
         end
      end
   end

   // Sticky events, write one to clear; a new event beats a clear
   always_comb begin
      irq_set                = '0;
      irq_set[IRQ_MATCH_BIT] = match_event; // R7
      irq_set[IRQ_PIN9_BIT]  = pin9_rise;
      irq_clr                = '0;
      if (wr_to(wr_acc, apb_req.paddr, OFF_IRQ_STATUS)) begin
         irq_clr = apb_req.pwdata[IRQ_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status <= IRQ_RESET;
      end else if (ce) begin
         irq_status <= (irq_status & ~irq_clr) | irq_set;
      end
   end

   // Level interrupt, high while any unmasked event is pending
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else if (ce) begin
         irq <= |(((irq_status & ~irq_clr) | irq_set) & irq_mask);
      end
   end

endmodule : ptc_time_clock

// ==== test/ptc_time_clock_monitor.sv ====
`timescale 1ns/1ns
module ptc_time_clock_monitor (
   input wire logic                  pclk,
   input wire logic                  presetn,
   input wire logic                  ce,
   input wire ptc_pkg::ptc_apb_req_t apb_req,
   input wire logic                  pin9_event,
   input wire logic [31:0]           prdata,
   input wire logic                  pready,
   input wire logic                  pslverr,
   input wire logic                  irq,
   input wire logic                  match_pulse,
   input wire logic [63:0]           time_now
);
   import ptc_pkg::*;
   logic wr_time;
   logic mapped;

   // Completed time word write; a commit may make the time jump
   assign wr_time = apb_req.psel && apb_req.penable && pready && apb_req.pwrite &&
                    (apb_req.paddr == OFF_TIME_UPPER || apb_req.paddr == OFF_TIME_LOWER);
   // Decoded offsets; anything else must answer with an error
   assign mapped = apb_req.paddr inside {OFF_PIN9_LOW, OFF_TIME_UPPER, OFF_TIME_LOWER,
      OFF_RATE_TRIM, OFF_MATCH_UPPER, OFF_MATCH_LOWER, OFF_REFILL_UP, OFF_REFILL_LOW,
      OFF_CONTROL, OFF_IRQ_STATUS, OFF_IRQ_MASK};

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_setup;
      apb_req.psel && !apb_req.penable && ce;
   endsequence
   sequence s_access;
      apb_req.psel && apb_req.penable && ce;
   endsequence

   property p_zero_wait;
      s_setup ##1 s_access |-> pready;
   endproperty
   property p_ready_access;
      pready |-> apb_req.psel && apb_req.penable && ce;
   endproperty
   property p_ready_single;
      pready |=> !pready;
   endproperty
   property p_err_map;
      s_setup ##1 s_access |-> pslverr == !mapped;
   endproperty
   property p_tick;
      $changed(time_now) && !$past(wr_time) |-> $past(ce) &&
         time_now == $past(time_now) + TICK_STEP;
   endproperty
   property p_freeze;
      !$past(ce) |-> $stable(time_now);
   endproperty
   property p_no_pulse;
      match_pulse == 1'b0;
   endproperty
   property p_rdata_hold;
      pready && !apb_req.pwrite ##1 !apb_req.psel |-> $stable(prdata);
   endproperty

   a_zero_wait: assert property (p_zero_wait) else $error("access not answered at once");
   a_ready_access: assert property (p_ready_access) else $error("pready outside access");
   a_ready_single: assert property (p_ready_single) else $error("pready held too long");
   a_err_map: assert property (p_err_map) else $error("pslverr does not match decode");
   a_tick: assert property (p_tick) else $error("time moved by other than one tick");
   a_freeze: assert property (p_freeze) else $error("time moved while disabled");
   a_no_pulse: assert property (p_no_pulse) else $error("reserved output not low");
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data not held");
   c_irq: cover property ($rose(irq));
endmodule : ptc_time_clock_monitor

bind ptc_time_clock ptc_time_clock_monitor u_mon (.pclk(pclk), .presetn(presetn), .ce(ce),
   .apb_req(apb_req), .pin9_event(pin9_event), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .irq(irq), .match_pulse(match_pulse), .time_now(time_now));

// ==== test/ptc_time_clock_bench.sv ====
`timescale 1ns/1ns
module ptc_time_clock_bench;
   import ptc_pkg::*;
   logic         pclk;
   logic         presetn;
   logic         ce;
   logic         pin9_event;
   ptc_apb_req_t req;
   logic [31:0]  prdata;
   logic         pready;
   logic         pslverr;
   logic         irq;
   logic         match_pulse;
   logic [63:0]  time_now;
   int           n_errors;
   int           n_compared;
   logic [31:0]  q;
   logic         e;
   logic [63:0]  t0;
   logic [63:0]  x;
   logic [63:0]  r;
   logic [11:0]  offs [11] = '{OFF_PIN9_LOW, OFF_TIME_UPPER, OFF_TIME_LOWER, OFF_RATE_TRIM,
      OFF_MATCH_UPPER, OFF_MATCH_LOWER, OFF_REFILL_UP, OFF_REFILL_LOW, OFF_CONTROL,
      OFF_IRQ_STATUS, OFF_IRQ_MASK};
   logic [11:0]  bad [3] = '{12'h18c, 12'h16d, 12'h1ac};

   ptc_time_clock u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .apb_req(req),
      .pin9_event(pin9_event), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .irq(irq), .match_pulse(match_pulse), .time_now(time_now));

   // Bus clock, 4 ns period
   always #2 pclk = ~pclk;

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // One APB transfer; an idle cycle follows so no signal is driven twice per step
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge pclk);
      req.penable <= 1'b1;
      // No wait-state count is assumed; only the watchdog ends a stuck access
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      #1;
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [11:0] a);
      apb(1'b0, a, 32'h0);
   endtask : rd

   task automatic wr64(input logic [11:0] ah, input logic [11:0] al, input logic [63:0] v);
      wr(ah, v[63:32]);
      wr(al, v[31:0]);
   endtask : wr64

   task automatic rd64(input logic [11:0] ah, input logic [11:0] al, output logic [63:0] v);
      rd(ah);
      v[63:32] = q;
      rd(al);
      v[31:0] = q;
   endtask : rd64

   task automatic wait_n(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask : wait_n

   task automatic test_done;
      if (n_errors == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : test_done

   // Watchdog: the sequence needs well under a thousand cycles
   initial begin
      #100000;
      n_errors++;
      test_done();
   end

   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      ce = 1'b1;
      pin9_event = 1'b0;
      req = '0;
      n_errors = 0;
      n_compared = 0;
      void'($urandom(32'hcac5e4cd));
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      // Reset values and decode
      foreach (offs[i]) begin
         rd(offs[i]);
         chk(64'(q), 64'(WORD_RESET));
         chk(64'(e), 64'h0);
      end
      foreach (bad[i]) begin
         rd(bad[i]);
         chk({31'h0, e, q}, 64'h100000000);
      end
      chk(time_now, TIME_RESET);
      // A lone upper half must not move the time
      x = {$urandom, $urandom};
      wr(OFF_TIME_UPPER, x[63:32]);
      wait_n(4);
      chk(time_now, TIME_RESET);
      wr(OFF_TIME_LOWER, x[31:0]);
      chk(time_now, x);
      // Reads return the frozen copy, not the live time
      wr(OFF_CONTROL, 32'h2);
      rd64(OFF_TIME_UPPER, OFF_TIME_LOWER, t0);
      chk(t0, x);
      r = {$urandom, $urandom};
      wr(OFF_TIME_LOWER, r[31:0]);
      wr(OFF_TIME_UPPER, r[63:32]);
      rd64(OFF_TIME_UPPER, OFF_TIME_LOWER, t0);
      chk(t0, x);
      wr(OFF_CONTROL, 32'h2);
      rd64(OFF_TIME_UPPER, OFF_TIME_LOWER, t0);
      chk(t0, r);
      // Match in reload mode, interrupt unmasked
      wr(OFF_CONTROL, 32'h1);
      wr(OFF_IRQ_MASK, 32'h1);
      wr64(OFF_REFILL_UP, OFF_REFILL_LOW, r);
      wr64(OFF_MATCH_UPPER, OFF_MATCH_LOWER, x);
      wr64(OFF_TIME_UPPER, OFF_TIME_LOWER, x);
      wait_n(3);
      chk(64'(irq), 64'h1);
      chk(64'(match_pulse), 64'h0);
      rd(OFF_IRQ_STATUS);
      chk(64'(q), 64'h1);
      rd64(OFF_MATCH_UPPER, OFF_MATCH_LOWER, t0);
      chk(t0, r);
      wr(OFF_IRQ_STATUS, 32'h1);
      wait_n(1);
      chk(64'(irq), 64'h0);
      // Add mode, masked; lone halves of target and reload stay staged
      wr(OFF_CONTROL, 32'h0);
      wr(OFF_IRQ_MASK, 32'h0);
      wr(OFF_MATCH_UPPER, $urandom);
      wr(OFF_REFILL_UP, $urandom);
      wr64(OFF_TIME_UPPER, OFF_TIME_LOWER, r);
      wait_n(3);
      chk(64'(irq), 64'h0);
      rd(OFF_IRQ_STATUS);
      chk(64'(q), 64'h1);
      rd64(OFF_MATCH_UPPER, OFF_MATCH_LOWER, t0);
      chk(t0, r + r);
      wr(OFF_IRQ_MASK, 32'h1);
      wait_n(1);
      chk(64'(irq), 64'h1);
      wr(OFF_IRQ_STATUS, 32'h3);
      rd(OFF_IRQ_STATUS);
      chk(64'(q), 64'h0);
      // Pin 9 capture: one per rising edge, word is read-only
      @(posedge pclk);
      pin9_event <= 1'b1;
      wait_n(2);
      rd(OFF_PIN9_LOW);
      chk(64'(q), 64'(r[31:0]));
      rd(OFF_IRQ_STATUS);
      chk(64'(q), 64'h2);
      wr(OFF_PIN9_LOW, $urandom);
      wr64(OFF_TIME_UPPER, OFF_TIME_LOWER, x);
      rd(OFF_PIN9_LOW);
      chk(64'(q), 64'(r[31:0]));
      @(posedge pclk);
      pin9_event <= 1'b0;
      @(posedge pclk);
      pin9_event <= 1'b1;
      wait_n(2);
      rd(OFF_PIN9_LOW);
      chk(64'(q), 64'(x[31:0]));
      // Quarter-wrap addend: exactly one tick per four cycles
      wr(OFF_RATE_TRIM, 32'h40000000);
      t0 = time_now;
      wait_n(400);
      chk(time_now - t0, 64'd100);
      rd(OFF_RATE_TRIM);
      chk(64'(q), 64'h40000000);
      // Clock enable low freezes the time
      @(posedge pclk);
      ce <= 1'b0;
      #1;
      t0 = time_now;
      wait_n(20);
      chk(time_now, t0);
      @(posedge pclk);
      ce <= 1'b1;
      test_done();
   end
endmodule : ptc_time_clock_bench
